// ### rtl/uec_endpoint_ctrl.sv
// Endpoint control and transmit status logic, banked by endpoint selector
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "uec_params.svh"
// Behaviour
// - Receive stall: OUT gets STALL, NAK if setup
// - Receive stall never blocks SETUP reception
// - Transmit stall: IN gets STALL, NAK if setup
// - SETUP accepted only on control endpoints
// - Single packet mode: one receive packet resident
// - Input disabled: no store, NAK OUT
// - SETUP data stored even with input disabled
// - Receive endpoint disabled: silent, highest priority
// - Reset loads endpoint 0 and others differently
// - Output disabled: NAK IN unless stalled
// - Transmit endpoint disabled: silent to IN
// - Hub control endpoint bits 5,4 fixed one
// - Toggle sent, flipped on ACK and SETUP
// - Toggle written only with overwrite bit
// - Isochronous full count at SOF with no IN since last SOF flushes oldest, selected endpoint only
// - Void set on NAK or STALL to IN
// - Error on no handshake or underrun, plus done unless isochronous
// - Acknowledge, plus done unless isochronous, exclusive with error
// - Flags at transaction end, isochronous at SOF
// - Banks selected by selector, contents kept
// - Setup flag set; NAK IN and OUT meanwhile
module uec_endpoint_ctrl #(
  parameter int NUM_EP = 3
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic tok_valid_i,
  input wire uec_pkg::uec_tok_t tok_kind_i,
  input wire logic [1:0] tok_ep_i,
  input wire logic tok_hub_i,
  output logic ans_valid_o,
  output uec_pkg::uec_ans_t ans_o,
  output logic ans_toggle_o,
  output logic rx_store_o,
  input wire logic tx_ready_i,
  input wire logic tx_end_i,
  input wire logic tx_handshake_i,
  input wire logic tx_underrun_i,
  input wire logic [1:0] tx_count_i,
  input wire logic [NUM_EP-1:0] tx_iso_i,
  input wire logic rx_release_i,
  input wire logic sof_i,
  output logic tx_flush_o,
  output logic [NUM_EP-1:0] tx_done_o
);
  // ==========================================================
  // Per-endpoint bank, hub control endpoint and the block state
  typedef struct packed {
    logic [7:0] cfg;
    logic setup;
    logic toggle;
    logic flushed;
    logic void_f;
    logic err;
    logic ack;
    logic pend_v;           // Isochronous outcome waiting for SOF
    logic pend_void;
    logic pend_err;
    logic pend_ack;
    logic in_seen;          // IN token seen since last SOF
  } uec_bank_t;
  typedef struct packed {
    uec_bank_t [NUM_EP-1:0] bank;
    logic [7:0] hub_cfg;    // Hub endpoint 0 config
    logic [7:0] sel;        // Endpoint selector
    logic [7:0] rdata;
    logic ans_valid;
    uec_pkg::uec_ans_t ans;
    logic ans_toggle;
    logic rx_store;
    logic tx_flush;
    logic [NUM_EP-1:0] done;
    logic [1:0] in_ep;      // Endpoint of the IN awaiting its end
    logic in_open;
  } uec_state_t;
  uec_state_t st_ff;
  uec_state_t nxt_st;
  // Selected function endpoint index
  logic [1:0] sel_idx;
  logic sel_hub;
  assign sel_idx = st_ff.sel[1:0];
  assign sel_hub = st_ff.sel[7];
  // Token target config and decision
  logic [7:0] tok_cfg;
  logic tok_setup;
  uec_pkg::uec_ans_t dec_ans;
  logic dec_store;
  logic [NUM_EP-1:0] rx_room;
  logic tok_room;
  always_comb begin
    tok_cfg = 8'h00;
    tok_setup = 1'b0;
    tok_room = 1'b0;
    if (tok_hub_i) begin
      tok_cfg = st_ff.hub_cfg;
      tok_room = 1'b1;
    end else if (int'(tok_ep_i) < NUM_EP) begin
      tok_cfg = st_ff.bank[tok_ep_i].cfg;
      tok_setup = st_ff.bank[tok_ep_i].setup;
      tok_room = rx_room[tok_ep_i];
    end
  end
  uec_token_decide u_decide (
    .cfg_i(tok_cfg),
    .setup_flag_i(tok_setup),
    .tx_ready_i(tx_ready_i),
    .rx_room_i(tok_room),
    .tok_i(tok_kind_i),
    .ans_o(dec_ans),
    .store_o(dec_store)
  );
  // ==========================================================
  // Receive occupancy per endpoint
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_occ
      uec_rx_occupancy u_occ (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .single_i(st_ff.bank[g].cfg[`UEC_CFG_RX_SINGLE_PACKET_MODE]),
        .clear_i(tok_valid_i && !tok_hub_i && tok_ep_i == 2'(g) && tok_kind_i == uec_pkg::UEC_TOK_SETUP),
        .stored_i(tok_valid_i && !tok_hub_i && tok_ep_i == 2'(g) && dec_store
                  && tok_kind_i == uec_pkg::UEC_TOK_OUT),
        .released_i(rx_release_i && !sel_hub && sel_idx == 2'(g)),
        .room_o(rx_room[g])
      );
    end
  endgenerate
  // ==========================================================
  // Next state: register writes, token answers, transmit outcomes
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ans_valid = 1'b0;
    nxt_st.rx_store = 1'b0;
    nxt_st.tx_flush = 1'b0;
    nxt_st.done = '0;
    nxt_st.rdata = 8'h00;
    // Register read: data valid in the following cycle
    if (rd_i) begin
      case (addr_i)
        `UEC_OFS_SELECTOR: nxt_st.rdata = st_ff.sel;
        `UEC_OFS_CONFIG: begin
          if (sel_hub) begin
            nxt_st.rdata = st_ff.hub_cfg;
          end else if (int'(sel_idx) < NUM_EP) begin
            nxt_st.rdata = st_ff.bank[sel_idx].cfg;
          end
        end
        `UEC_OFS_RECEIVE_STATUS: begin
          if (!sel_hub && int'(sel_idx) < NUM_EP) begin
            nxt_st.rdata[`UEC_RX_SETUP] = st_ff.bank[sel_idx].setup;
          end
        end
        `UEC_OFS_TRANSMIT_STATUS: begin
          if (!sel_hub && int'(sel_idx) < NUM_EP) begin
            // Overwrite bit and reserved bits read zero
            nxt_st.rdata[`UEC_TX_TOGGLE] = st_ff.bank[sel_idx].toggle;
            nxt_st.rdata[`UEC_TX_FLUSHED] = st_ff.bank[sel_idx].flushed;
            nxt_st.rdata[`UEC_TX_VOID] = st_ff.bank[sel_idx].void_f;
            nxt_st.rdata[`UEC_TX_ERR] = st_ff.bank[sel_idx].err;
            nxt_st.rdata[`UEC_TX_ACK] = st_ff.bank[sel_idx].ack;
          end
        end
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    // Register write; hardware events below take priority
    if (wr_i) begin
      case (addr_i)
        `UEC_OFS_SELECTOR: nxt_st.sel = wdata_i;
        `UEC_OFS_CONFIG: begin
          if (sel_hub) begin
            nxt_st.hub_cfg = wdata_i | 8'h30;
          end else if (int'(sel_idx) < NUM_EP) begin
            nxt_st.bank[sel_idx].cfg = wdata_i;
          end
        end
        `UEC_OFS_RECEIVE_STATUS: begin
          // Firmware may only clear the setup flag
          if (!sel_hub && int'(sel_idx) < NUM_EP && !wdata_i[`UEC_RX_SETUP]) begin
            nxt_st.bank[sel_idx].setup = 1'b0;
          end
        end
        `UEC_OFS_TRANSMIT_STATUS: begin
          // Reserved bits 6:5 are ignored; firmware writes zeros there
          if (!sel_hub && int'(sel_idx) < NUM_EP && wdata_i[`UEC_TX_OVW]) begin
            nxt_st.bank[sel_idx].toggle = wdata_i[`UEC_TX_TOGGLE];
          end
        end
        default: ;
      endcase
    end
    // Token answer one cycle after the token
    if (tok_valid_i) begin
      nxt_st.ans_valid = 1'b1;
      nxt_st.ans = dec_ans;
      nxt_st.rx_store = dec_store;
      nxt_st.ans_toggle = 1'b0;
      if (!tok_hub_i && int'(tok_ep_i) < NUM_EP) begin
        nxt_st.ans_toggle = st_ff.bank[tok_ep_i].toggle;
        if (tok_kind_i == uec_pkg::UEC_TOK_SETUP && dec_store) begin
          nxt_st.bank[tok_ep_i].setup = 1'b1;
          nxt_st.bank[tok_ep_i].toggle = ~st_ff.bank[tok_ep_i].toggle;
        end
        if (tok_kind_i == uec_pkg::UEC_TOK_IN) begin
          nxt_st.bank[tok_ep_i].in_seen = 1'b1;
          if (dec_ans == uec_pkg::UEC_ANS_NAK || dec_ans == uec_pkg::UEC_ANS_STALL) begin
            // Void only, done/error/ack left alone
            if (tx_iso_i[tok_ep_i]) begin
              nxt_st.bank[tok_ep_i].pend_v = 1'b1;
              nxt_st.bank[tok_ep_i].pend_void = 1'b1;
            end else begin
              nxt_st.bank[tok_ep_i].void_f = 1'b1;
            end
          end else if (dec_ans == uec_pkg::UEC_ANS_ACK) begin
            nxt_st.in_ep = tok_ep_i;
            nxt_st.in_open = 1'b1;
          end
        end
      end
    end
    // Transmission end: acknowledge or error, never both
    if (tx_end_i && st_ff.in_open) begin
      nxt_st.in_open = 1'b0;
      if (tx_iso_i[st_ff.in_ep]) begin
        nxt_st.bank[st_ff.in_ep].pend_v = 1'b1;
        nxt_st.bank[st_ff.in_ep].pend_void = 1'b0;
        nxt_st.bank[st_ff.in_ep].pend_ack = tx_handshake_i && !tx_underrun_i;
        nxt_st.bank[st_ff.in_ep].pend_err = !tx_handshake_i || tx_underrun_i;
      end else begin
        nxt_st.bank[st_ff.in_ep].void_f = 1'b0;
        nxt_st.bank[st_ff.in_ep].ack = tx_handshake_i && !tx_underrun_i;
        nxt_st.bank[st_ff.in_ep].err = !tx_handshake_i || tx_underrun_i;
        nxt_st.done[st_ff.in_ep] = 1'b1;
      end
      if (tx_handshake_i && !tx_underrun_i) begin
        nxt_st.bank[st_ff.in_ep].toggle = ~st_ff.bank[st_ff.in_ep].toggle;
      end
    end
    // SOF: publish isochronous outcomes and flush stale packets
    if (sof_i) begin
      for (int i = 0; i < NUM_EP; i++) begin
        nxt_st.bank[i].in_seen = 1'b0;
        if (st_ff.bank[i].pend_v) begin
          nxt_st.bank[i].pend_v = 1'b0;
          nxt_st.bank[i].void_f = st_ff.bank[i].pend_void;
          nxt_st.bank[i].err = st_ff.bank[i].pend_err;
          nxt_st.bank[i].ack = st_ff.bank[i].pend_ack;
        end
        if (tx_iso_i[i] && !st_ff.bank[i].in_seen && tx_count_i == `UEC_TXCNT_FULL
            && !sel_hub && sel_idx == 2'(i)) begin
          nxt_st.bank[i].flushed = 1'b1;
          nxt_st.tx_flush = 1'b1;
        end
      end
    end
  end
  // ==========================================================
  // Register the state; reset loads per-endpoint config values
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
      for (int i = 0; i < NUM_EP; i++) begin
        st_ff.bank[i].cfg <= (i == 0) ? `UEC_RST_CFG_EP0 : `UEC_RST_CFG_EPN;
      end
      st_ff.hub_cfg <= `UEC_RST_CFG_EP0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end
  // Outputs straight from flip-flops
  assign rdata_o = st_ff.rdata;
  assign ans_valid_o = st_ff.ans_valid;
  assign ans_o = st_ff.ans;
  assign ans_toggle_o = st_ff.ans_toggle;
  assign rx_store_o = st_ff.rx_store;
  assign tx_flush_o = st_ff.tx_flush;
  assign tx_done_o = st_ff.done;
  // ==========================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_setup_tok;
    ce_i && tok_valid_i && !tok_hub_i && tok_ep_i == 2'h0 && tok_kind_i == uec_pkg::UEC_TOK_SETUP;
  endsequence
  setup_control_endpoint_cfg_a: assert property (s_setup_tok ##1 (ans_valid_o && ans_o == uec_pkg::UEC_ANS_ACK)
    |-> $past(st_ff.bank[0].cfg[`UEC_CFG_CONTROL_ENDPOINT_CFG])) else $error("setup accepted on non control endpoint");
  rx_disable_a: assert property (s_setup_tok and !st_ff.bank[0].cfg[`UEC_CFG_RX_ENDPOINT_ENABLE]
    |=> ans_o == uec_pkg::UEC_ANS_NONE) else $error("disabled endpoint answered");
  ack_err_excl_a: assert property (!(st_ff.bank[0].ack && st_ff.bank[0].err))
    else $error("ack and error together");
  hub_fixed_a: assert property (st_ff.hub_cfg[5:4] == 2'h3) else $error("hub bits changed");
  setup_nak_a: assert property (ce_i && tok_valid_i && !tok_hub_i && tok_ep_i == 2'h0
    && tok_kind_i == uec_pkg::UEC_TOK_IN && st_ff.bank[0].setup && st_ff.bank[0].cfg[`UEC_CFG_TX_ENDPOINT_ENABLE]
    |=> ans_o == uec_pkg::UEC_ANS_NAK) else $error("IN not NAKed during setup");
  toggle_keep_a: assert property (ce_i && wr_i && addr_i == `UEC_OFS_TRANSMIT_STATUS && !wdata_i[`UEC_TX_OVW]
    && !tok_valid_i && !tx_end_i |=> $stable(st_ff.bank[0].toggle)) else $error("toggle changed");
  stall_in_a: assert property (ce_i && tok_valid_i && !tok_hub_i && tok_ep_i == 2'h1
    && tok_kind_i == uec_pkg::UEC_TOK_IN && st_ff.bank[1].cfg[`UEC_CFG_TX_ENDPOINT_ENABLE]
    && st_ff.bank[1].cfg[`UEC_CFG_TXSTALL] && !st_ff.bank[1].setup
    |=> ans_o == uec_pkg::UEC_ANS_STALL) else $error("stalled IN not STALLed");
  out_nak_a: assert property (ce_i && tok_valid_i && !tok_hub_i && tok_ep_i == 2'h1
    && tok_kind_i == uec_pkg::UEC_TOK_OUT && st_ff.bank[1].cfg[2] && !st_ff.bank[1].cfg[7]
    && !st_ff.bank[1].cfg[3] && !st_ff.bank[1].setup |=> ans_o == uec_pkg::UEC_ANS_NAK && !rx_store_o)
    else $error("disabled input not NAKed");
endmodule : uec_endpoint_ctrl

// ### rtl/uec_params.svh
// Register offsets, field positions and reset values for the endpoint control block
`ifndef UEC_PARAMS_SVH
`define UEC_PARAMS_SVH
// ==========================================================
// Register offsets
`define UEC_OFS_SELECTOR 8'hF1
`define UEC_OFS_CONFIG 8'hE1
`define UEC_OFS_RECEIVE_STATUS 8'hE2
`define UEC_OFS_TRANSMIT_STATUS 8'hF2
// ==========================================================
// Endpoint config field positions
`define UEC_CFG_RXSTALL 7
`define UEC_CFG_TXSTALL 6
`define UEC_CFG_CONTROL_ENDPOINT_CFG 5
`define UEC_CFG_RX_SINGLE_PACKET_MODE 4
`define UEC_CFG_RX_INPUT_ENABLE 3
`define UEC_CFG_RX_ENDPOINT_ENABLE 2
`define UEC_CFG_TX_OUTPUT_ENABLE 1
`define UEC_CFG_TX_ENDPOINT_ENABLE 0
// ==========================================================
// Transmit status field positions
`define UEC_TX_TOGGLE 7
`define UEC_TX_FLUSHED 4
`define UEC_TX_OVW 3
`define UEC_TX_VOID 2
`define UEC_TX_ERR 1
`define UEC_TX_ACK 0
// Receive status: setup received flag
`define UEC_RX_SETUP 6
// ==========================================================
// Reset values
`define UEC_RST_CFG_EP0 8'h35
`define UEC_RST_CFG_EPN 8'h10
`define UEC_RST_STATUS 8'h00
// Hub control endpoint selector value
`define UEC_SEL_HUB0 8'h80
// Transmit packet count that triggers a stale flush
`define UEC_TXCNT_FULL 2'h3
`endif

// ### rtl/uec_pkg.sv
// Types shared by the endpoint control block
package uec_pkg;
  // ==========================================================
  // Handshake answer to a token
  typedef enum logic [1:0] {
    UEC_ANS_NONE,
    UEC_ANS_ACK,
    UEC_ANS_NAK,
    UEC_ANS_STALL
  } uec_ans_t;
  // Token kind from the serial engine
  typedef enum logic [1:0] {
    UEC_TOK_OUT,
    UEC_TOK_IN,
    UEC_TOK_SETUP,
    UEC_TOK_OTHER
  } uec_tok_t;
endpackage : uec_pkg

// ### rtl/uec_token_decide.sv
// Combinational handshake decision for one token on the token's target endpoint
`timescale 1ns/1ps
`include "uec_params.svh"
module uec_token_decide (
  input wire logic [7:0] cfg_i,
  input wire logic setup_flag_i,
  input wire logic tx_ready_i,
  input wire logic rx_room_i,
  input wire uec_pkg::uec_tok_t tok_i,
  output uec_pkg::uec_ans_t ans_o,
  output logic store_o
);
  // ==========================================================
  // Decision order: endpoint enable, setup lock, stall, input or output enable
  always_comb begin
    ans_o = uec_pkg::UEC_ANS_NONE;
    store_o = 1'b0;
    case (tok_i)
      uec_pkg::UEC_TOK_SETUP: begin
        // Stall and input enable do not gate setup
        if (cfg_i[`UEC_CFG_RX_ENDPOINT_ENABLE] && cfg_i[`UEC_CFG_CONTROL_ENDPOINT_CFG]) begin
          ans_o = uec_pkg::UEC_ANS_ACK;
          store_o = 1'b1;
        end
      end
      uec_pkg::UEC_TOK_OUT: begin
        if (!cfg_i[`UEC_CFG_RX_ENDPOINT_ENABLE]) begin
          ans_o = uec_pkg::UEC_ANS_NONE;
        end else if (setup_flag_i) begin
          ans_o = uec_pkg::UEC_ANS_NAK;
        end else if (cfg_i[`UEC_CFG_RXSTALL]) begin
          ans_o = uec_pkg::UEC_ANS_STALL;
        end else if (!cfg_i[`UEC_CFG_RX_INPUT_ENABLE] || !rx_room_i) begin
          ans_o = uec_pkg::UEC_ANS_NAK;
        end else begin
          ans_o = uec_pkg::UEC_ANS_ACK;
          store_o = 1'b1;
        end
      end
      uec_pkg::UEC_TOK_IN: begin
        if (!cfg_i[`UEC_CFG_TX_ENDPOINT_ENABLE]) begin
          ans_o = uec_pkg::UEC_ANS_NONE;
        end else if (setup_flag_i) begin
          ans_o = uec_pkg::UEC_ANS_NAK;
        end else if (cfg_i[`UEC_CFG_TXSTALL]) begin
          ans_o = uec_pkg::UEC_ANS_STALL;
        end else if (!cfg_i[`UEC_CFG_TX_OUTPUT_ENABLE] || !tx_ready_i) begin
          ans_o = uec_pkg::UEC_ANS_NAK;
        end else begin
          ans_o = uec_pkg::UEC_ANS_ACK;
        end
      end
      default: begin
        ans_o = uec_pkg::UEC_ANS_NONE;
      end
    endcase
  end
endmodule : uec_token_decide

// ### rtl/uec_rx_occupancy.sv
// Receive packet occupancy count for one endpoint, limited by single packet mode
`timescale 1ns/1ps
module uec_rx_occupancy (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic single_i,
  input wire logic clear_i,
  input wire logic stored_i,
  input wire logic released_i,
  output logic room_o
);
  // ==========================================================
  // State: packets held in the receive FIFO
  typedef struct packed {
    logic [1:0] cnt;
  } uec_occ_t;
  uec_occ_t st_ff;
  uec_occ_t nxt_st;
  // Next count: store adds, firmware release removes
  always_comb begin
    nxt_st = st_ff;
    if (clear_i) begin
      nxt_st.cnt = 2'h0;
    end else if (stored_i && !released_i && st_ff.cnt != 2'h2) begin
      nxt_st.cnt = st_ff.cnt + 2'h1;
    end else if (!stored_i && released_i && st_ff.cnt != 2'h0) begin
      nxt_st.cnt = st_ff.cnt - 2'h1;
    end
  end
  // Register the state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end
  // Single packet mode allows one resident packet, otherwise two
  assign room_o = single_i ? (st_ff.cnt == 2'h0) : (st_ff.cnt != 2'h2);
endmodule : uec_rx_occupancy

// ### testbench/uec_host_model.sv
// Serial engine stand-in: issues tokens and closes IN data stages
`timescale 1ns/1ps
module uec_host_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic go_i,
  input wire uec_pkg::uec_tok_t kind_i,
  input wire logic [1:0] ep_i,
  input wire logic host_ack_i,
  input wire logic ans_valid_i,
  input wire uec_pkg::uec_ans_t ans_i,
  output logic tok_valid_o,
  output uec_pkg::uec_tok_t tok_kind_o,
  output logic [1:0] tok_ep_o,
  output logic tx_end_o,
  output logic tx_handshake_o
);
  logic last_in; // Last token issued was IN
  logic pend; // Data stage running, end comes next cycle
  // ==========================================================
  // Token issue and end of the IN data stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tok_valid_o <= 1'b0;
      tok_kind_o <= uec_pkg::UEC_TOK_OTHER;
      tok_ep_o <= 2'h0;
      tx_end_o <= 1'b0;
      tx_handshake_o <= 1'b0;
      last_in <= 1'b0;
      pend <= 1'b0;
    end else begin
      tok_valid_o <= go_i;
      // Idle lines wander so a stale value is never mistaken for a token
      tok_kind_o <= go_i ? kind_i : uec_pkg::UEC_TOK_OTHER;
      tok_ep_o <= go_i ? ep_i : ~tok_ep_o;
      if (go_i) begin
        last_in <= (kind_i == uec_pkg::UEC_TOK_IN);
      end
      // Host answers only data that the device really sent
      pend <= ans_valid_i && last_in && (ans_i == uec_pkg::UEC_ANS_ACK);
      tx_end_o <= pend;
      tx_handshake_o <= pend ? host_ack_i : ~tx_handshake_o;
    end
  end
endmodule : uec_host_model

// ### testbench/tb_uec_endpoint_ctrl.sv
// Self-checking bench for the endpoint control block
`timescale 1ns/1ps
`include "uec_params.svh"
module tb_uec_endpoint_ctrl;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0, go = 1'b0, host_ack = 1'b0;
  uec_pkg::uec_tok_t kind = uec_pkg::UEC_TOK_OTHER, tok_kind;
  logic [1:0] ep = 2'h0, tok_ep, tx_count = 2'h0;
  logic tok_valid, ans_valid, ans_tog, rx_store, tx_end, tx_hs, tx_flush;
  uec_pkg::uec_ans_t ans;
  logic tx_ready = 1'b0, rx_rel = 1'b0, sof = 1'b0;
  logic [2:0] tx_iso = 3'h0, tx_done;
  int n_mismatch = 0, compares = 0;
  // Answer captured by the token task
  uec_pkg::uec_ans_t g_ans;
  logic g_st, g_tog;
  // Bench copies of setup flags and toggles, one per endpoint
  logic [2:0] st = 3'h0, tg = 3'h0;
  // ==========================================================
  // Clock 100 ns period
  always #50 clk_i = ~clk_i;
  uec_endpoint_ctrl #(.NUM_EP(3)) uec_endpoint_ctrl_i (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tok_valid_i(tok_valid),
    .tok_kind_i(tok_kind), .tok_ep_i(tok_ep), .tok_hub_i(1'b0), .ans_valid_o(ans_valid), .ans_o(ans),
    .ans_toggle_o(ans_tog), .rx_store_o(rx_store), .tx_ready_i(tx_ready), .tx_end_i(tx_end),
    .tx_handshake_i(tx_hs), .tx_underrun_i(1'b0), .tx_count_i(tx_count), .tx_iso_i(tx_iso),
    .rx_release_i(rx_rel), .sof_i(sof), .tx_flush_o(tx_flush), .tx_done_o(tx_done));
  uec_host_model uec_host_model_i (.clk_i(clk_i), .reset_i(reset_i), .go_i(go), .kind_i(kind), .ep_i(ep),
    .host_ack_i(host_ack), .ans_valid_i(ans_valid), .ans_i(ans), .tok_valid_o(tok_valid),
    .tok_kind_o(tok_kind), .tok_ep_o(tok_ep), .tx_end_o(tx_end), .tx_handshake_o(tx_hs));
  // ==========================================================
  // Reporting
  task automatic test_done();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // ==========================================================
  // Register bus: one-cycle strobes, read data in the next cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic pulse_rel();
    @(posedge clk_i);
    rx_rel <= 1'b1;
    @(posedge clk_i);
    rx_rel <= 1'b0;
  endtask : pulse_rel
  // Ask the host model for one token and capture the answer cycle
  task automatic token(input uec_pkg::uec_tok_t k, input logic [1:0] e);
    int i;
    @(posedge clk_i);
    kind <= k;
    ep <= e;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    i = 0;
    do begin
      @(posedge clk_i);
      #1;
      i++;
    end while (ans_valid !== 1'b1 && i < 8);
    if (ans_valid !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
    g_ans = ans;
    g_st = rx_store;
    g_tog = ans_tog;
  endtask : token
  // Expected handshake; disable outranks setup, setup outranks stall
  function automatic uec_pkg::uec_ans_t exp_ans(input logic [7:0] c, input logic s, input uec_pkg::uec_tok_t k,
      input logic rdy);
    if (k == uec_pkg::UEC_TOK_IN) begin
      if (!c[0]) return uec_pkg::UEC_ANS_NONE;
      if (s) return uec_pkg::UEC_ANS_NAK;
      if (c[6]) return uec_pkg::UEC_ANS_STALL;
      if (!c[1] || !rdy) return uec_pkg::UEC_ANS_NAK;
      return uec_pkg::UEC_ANS_ACK;
    end
    if (!c[2]) return uec_pkg::UEC_ANS_NONE;
    if (k == uec_pkg::UEC_TOK_SETUP) return c[5] ? uec_pkg::UEC_ANS_ACK : uec_pkg::UEC_ANS_NONE;
    if (s) return uec_pkg::UEC_ANS_NAK;
    if (c[7]) return uec_pkg::UEC_ANS_STALL;
    if (!c[3]) return uec_pkg::UEC_ANS_NAK;
    return uec_pkg::UEC_ANS_ACK;
  endfunction : exp_ans
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] d, c;
    logic [1:0] e;
    uec_pkg::uec_tok_t k;
    uec_pkg::uec_ans_t x;
    int i, j;
    void'($urandom(81));
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    // Reset contents of every bank, hub fixed bits after a zero write and an unmapped place
    for (i = 0; i < 3; i++) begin
      wr_reg(`UEC_OFS_SELECTOR, 8'(i));
      rd_reg(`UEC_OFS_CONFIG, d);
      chk("cfg_rst", d, (i == 0) ? `UEC_RST_CFG_EP0 : `UEC_RST_CFG_EPN);
      rd_reg(`UEC_OFS_RECEIVE_STATUS, d);
      chk("receive_status_rst", d, 8'h00);
      rd_reg(`UEC_OFS_TRANSMIT_STATUS, d);
      chk("transmit_status_rst", d & 8'h9F, 8'h00);
    end
    wr_reg(`UEC_OFS_SELECTOR, `UEC_SEL_HUB0);
    wr_reg(`UEC_OFS_CONFIG, 8'h00);
    rd_reg(`UEC_OFS_CONFIG, d);
    chk("hub_fixed", d & 8'h30, 8'h30);
    rd_reg(8'h00, d);
    chk("unmapped", d, 8'h00);
    // Toggle written only together with the overwrite bit; overwrite bit reads zero
    wr_reg(`UEC_OFS_SELECTOR, 8'h01);
    wr_reg(`UEC_OFS_TRANSMIT_STATUS, 8'h80);
    rd_reg(`UEC_OFS_TRANSMIT_STATUS, d);
    chk("tog_no_ovw", d & 8'h88, 8'h00);
    wr_reg(`UEC_OFS_TRANSMIT_STATUS, 8'h88);
    rd_reg(`UEC_OFS_TRANSMIT_STATUS, d);
    chk("tog_ovw", d & 8'h88, 8'h80);
    wr_reg(`UEC_OFS_TRANSMIT_STATUS, 8'h08);
    // Output disabled: NAK, void flag raised
    wr_reg(`UEC_OFS_CONFIG, 8'h01);
    token(uec_pkg::UEC_TOK_IN, 2'h1);
    chk("ans_void", {6'h00, g_ans}, {6'h00, uec_pkg::UEC_ANS_NAK});
    repeat (3) @(posedge clk_i);
    rd_reg(`UEC_OFS_TRANSMIT_STATUS, d);
    chk("void_flag", d & 8'h07, 8'h04);
    // Single mode holds one packet, dual mode two
    wr_reg(`UEC_OFS_SELECTOR, 8'h02);
    for (j = 1; j <= 2; j++) begin
      wr_reg(`UEC_OFS_CONFIG, (j == 1) ? 8'h1C : 8'h0C);
      for (i = 0; i <= j; i++) begin
        token(uec_pkg::UEC_TOK_OUT, 2'h2);
        x = (i < j) ? uec_pkg::UEC_ANS_ACK : uec_pkg::UEC_ANS_NAK;
        chk("occupancy", {5'h00, g_st, g_ans}, {5'h00, x == uec_pkg::UEC_ANS_ACK, x});
      end
      repeat (j) pulse_rel();
    end
    // Random configurations and tokens on all endpoints
    for (i = 0; i < 40; i++) begin
      e = 2'($urandom % 3);
      c = 8'($urandom);
      k = uec_pkg::uec_tok_t'($urandom % 3);
      tx_ready <= 1'($urandom);
      host_ack <= 1'($urandom);
      wr_reg(`UEC_OFS_SELECTOR, {6'h00, e});
      wr_reg(`UEC_OFS_CONFIG, c);
      rd_reg(`UEC_OFS_CONFIG, d);
      chk("cfg_rw", d, c);
      token(k, e);
      x = exp_ans(c, st[e], k, tx_ready);
      chk("answer", {6'h00, g_ans}, {6'h00, x});
      if (k != uec_pkg::UEC_TOK_IN) begin
        chk("store", {7'h00, g_st}, {7'h00, x == uec_pkg::UEC_ANS_ACK});
        if (x == uec_pkg::UEC_ANS_ACK) pulse_rel();
        if (k == uec_pkg::UEC_TOK_SETUP && x == uec_pkg::UEC_ANS_ACK) begin
          st[e] = 1'b1;
          tg[e] = ~tg[e];
        end
      end else if (x == uec_pkg::UEC_ANS_ACK) begin
        chk("pid_tog", {7'h00, g_tog}, {7'h00, tg[e]});
        j = 0;
        do begin
          @(posedge clk_i);
          #1;
          j++;
        end while (tx_done === 3'h0 && j < 10);
        chk("tx_done", {5'h00, tx_done}, 8'(3'h1 << e));
        if (host_ack) tg[e] = ~tg[e];
        rd_reg(`UEC_OFS_TRANSMIT_STATUS, d);
        chk("tx_flags", d & 8'h83, {tg[e], 5'h00, host_ack ? 2'b01 : 2'b10});
      end
      rd_reg(`UEC_OFS_RECEIVE_STATUS, d);
      chk("setup_flag", d & 8'h40, {1'b0, st[e], 6'h00});
      if ($urandom % 2) begin
        wr_reg(`UEC_OFS_RECEIVE_STATUS, 8'h00);
        st[e] = 1'b0;
      end
    end
    // Isochronous: flags wait for SOF, full count is flushed
    wr_reg(`UEC_OFS_SELECTOR, 8'h01);
    wr_reg(`UEC_OFS_RECEIVE_STATUS, 8'h00);
    wr_reg(`UEC_OFS_CONFIG, 8'h03);
    tx_iso <= 3'h2;
    tx_ready <= 1'b1;
    host_ack <= 1'b1;
    // Flags left by the random phase must survive until the SOF
    rd_reg(`UEC_OFS_TRANSMIT_STATUS, c);
    token(uec_pkg::UEC_TOK_IN, 2'h1);
    repeat (6) @(posedge clk_i);
    rd_reg(`UEC_OFS_TRANSMIT_STATUS, d);
    chk("iso_before", d & 8'h03, c & 8'h03);
    for (j = 0; j < 2; j++) begin
      @(posedge clk_i);
      sof <= 1'b1;
      tx_count <= 2'(j * 3);
      @(posedge clk_i);
      sof <= 1'b0;
      #1;
      chk("flush", {7'h00, tx_flush}, {7'h00, j == 1});
      rd_reg(`UEC_OFS_TRANSMIT_STATUS, d);
      chk("iso_after", d & 8'h13, (j == 1) ? 8'h11 : 8'h01);
    end
    test_done();
  end
endmodule : tb_uec_endpoint_ctrl
